/* ipc_pkg.sv */
// shared constants and types for the interrupt priority and channel transfer block
package ipc_pkg;
    // channel and slot counts
    localparam int NUM_CH = 50;
    localparam int NUM_EXT = 42;
    localparam int NUM_SLOT = 8;
    localparam int TC_BASE = 42;
    localparam int NUM_LVL_REG = 25;

    // priority levels
    localparam logic [2:0] LVL_OFF = 3'h0;
    localparam logic [2:0] LVL_DMA = 3'h6;
    localparam logic [2:0] LVL_NMI = 3'h7;

    // vectors
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_STEP = 8'h01;
    localparam logic [7:0] NMI_VECTOR = 8'h3f;

    // cpu register port map
    localparam logic [7:0] LEVEL_BASE = 8'h00;
    localparam logic [7:0] VEC_BASE = 8'h20;
    localparam logic [7:0] CLEAR_ADDR = 8'h28;
    localparam logic [7:0] MODE_BASE = 8'h30;

    // level register field layout
    localparam int LVL_LO_LSB = 0;
    localparam int FLAG_LO_BIT = 3;
    localparam int LVL_HI_LSB = 4;
    localparam int FLAG_HI_BIT = 7;

    // control register selects for the load-control port
    localparam logic [1:0] LDC_SRC = 2'h0;
    localparam logic [1:0] LDC_DST = 2'h1;
    localparam logic [1:0] LDC_CNT = 2'h2;

    // transfer mode encodings
    localparam logic [2:0] MODE_DST_INC = 3'h0;
    localparam logic [2:0] MODE_DST_DEC = 3'h1;
    localparam logic [2:0] MODE_SRC_INC = 3'h2;
    localparam logic [2:0] MODE_SRC_DEC = 3'h3;
    localparam logic [2:0] MODE_BOTH_INC = 3'h4;
    localparam logic [2:0] MODE_BOTH_DEC = 3'h5;
    localparam logic [2:0] MODE_FIXED = 3'h6;
    localparam logic [4:0] MODE_COUNTER = 5'h1c;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // timing: one bus state, in ns, against the 40 MHz system clock
    localparam int STATE_NS = 50;
    localparam int CLK_NS = 25;
    localparam int STATE_CYCLES = (STATE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] STATES_SINGLE = 3'h5;
    localparam logic [2:0] STATES_BOTH = 3'h6;
    localparam logic [3:0] READ_CYC = 4'(2 * STATE_CYCLES);
    localparam logic [3:0] WRITE_CYC = 4'(3 * STATE_CYCLES);

    typedef enum logic {DMA_IDLE, DMA_RUN} ipc_dma_state_t;
endpackage : ipc_pkg

/* ipc_links.sv */
// interfaces joining the top module to its arbiter and its pointer stepper
`timescale 1ns/1ps
interface ipc_arb_if;
    logic [ipc_pkg::NUM_CH-1:0] pending;
    logic [ipc_pkg::NUM_CH-1:0][2:0] level;
    logic winValid;
    logic [5:0] winIdx;
    logic [2:0] winLevel;
    modport user (output pending, output level, input winValid, input winIdx, input winLevel);
    modport arb (input pending, input level, output winValid, output winIdx, output winLevel);
endinterface : ipc_arb_if

interface ipc_step_if;
    logic [7:0] mode;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] cnt;
    logic [31:0] nextSrc;
    logic [31:0] nextDst;
    logic [15:0] nextCnt;
    logic moves;
    logic [2:0] totalStates;
    logic [1:0] size;
    modport user (output mode, output src, output dst, output cnt, input nextSrc,
        input nextDst, input nextCnt, input moves, input totalStates, input size);
    modport calc (input mode, input src, input dst, input cnt, output nextSrc,
        output nextDst, output nextCnt, output moves, output totalStates, output size);
endinterface : ipc_step_if

/* ipc_arbiter.sv */
// level-then-default-order arbiter over the maskable request flags
`timescale 1ns/1ps
module ipc_arbiter (
    ipc_arb_if.arb arbIf
);
    // scan from the top index down so a tie keeps the lowest vector
    always_comb begin
        arbIf.winValid = 1'b0;
        arbIf.winIdx = 6'h00;
        arbIf.winLevel = ipc_pkg::LVL_OFF;
        for (int i = ipc_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (arbIf.pending[i] && arbIf.level[i] != ipc_pkg::LVL_OFF &&
                arbIf.level[i] != ipc_pkg::LVL_NMI && arbIf.level[i] >= arbIf.winLevel) begin
                arbIf.winValid = 1'b1;
                arbIf.winIdx = 6'(i);
                arbIf.winLevel = arbIf.level[i];
            end
        end
    end
endmodule : ipc_arbiter

/* ipc_step.sv */
// decodes a channel mode and works out the pointers and count after one transfer
`timescale 1ns/1ps
module ipc_step (
    ipc_step_if.calc stepIf
);
    // byte count of one data unit
    function automatic logic [31:0] unitBytes(input logic [1:0] sz);
        unique case (sz)
            ipc_pkg::SIZE_BYTE: unitBytes = 32'h0000_0001;
            ipc_pkg::SIZE_HALF: unitBytes = 32'h0000_0002;
            ipc_pkg::SIZE_WORD: unitBytes = 32'h0000_0004;
            default: unitBytes = 32'h0000_0000;
        endcase
    endfunction : unitBytes

    logic [31:0] stepBytes;
    logic isCounter;

    // pointers move only after the transfer, by the unit size
    always_comb begin
        stepBytes = unitBytes(stepIf.mode[1:0]);
        isCounter = stepIf.mode[4:0] == ipc_pkg::MODE_COUNTER;
        stepIf.size = stepIf.mode[1:0];
        stepIf.nextSrc = stepIf.src;
        stepIf.nextDst = stepIf.dst;
        stepIf.nextCnt = stepIf.cnt - 16'h0001;
        stepIf.moves = !isCounter;
        stepIf.totalStates = ipc_pkg::STATES_SINGLE;
        unique case (stepIf.mode[4:2])
            ipc_pkg::MODE_DST_INC: stepIf.nextDst = stepIf.dst + stepBytes;
            ipc_pkg::MODE_DST_DEC: stepIf.nextDst = stepIf.dst - stepBytes;
            ipc_pkg::MODE_SRC_INC: stepIf.nextSrc = stepIf.src + stepBytes;
            ipc_pkg::MODE_SRC_DEC: stepIf.nextSrc = stepIf.src - stepBytes;
            ipc_pkg::MODE_BOTH_INC: begin
                stepIf.nextSrc = stepIf.src + stepBytes;
                stepIf.nextDst = stepIf.dst + stepBytes;
                stepIf.totalStates = ipc_pkg::STATES_BOTH;
            end
            ipc_pkg::MODE_BOTH_DEC: begin
                stepIf.nextSrc = stepIf.src - stepBytes;
                stepIf.nextDst = stepIf.dst - stepBytes;
                stepIf.totalStates = ipc_pkg::STATES_BOTH;
            end
            ipc_pkg::MODE_FIXED: stepIf.nextSrc = stepIf.src;
            default: begin
                if (isCounter) begin
                    stepIf.nextSrc = stepIf.src + 32'h0000_0001;
                end
            end
        endcase
    end
endmodule : ipc_step

/* ipc_top.sv */
// interrupt priority controller with eight source-triggered transfer channels
// How it works
// - upper mode bits 000-011 step only destination or source, up or down
// - upper mode bits 100/101 step both pointers up/down; six states per transfer
// - upper mode bits 110 move one unit, leave both pointers unchanged
// - mode 11100 moves nothing; source pointer plus one, count minus one
// - low mode bits give unit size: one, two or four bytes; 11 reserved
// - every transfer decrements the count; reaching zero raises the transfer-end request
// - the current pointer is used, then stepped by the unit size
// - fifty channels, each with flag, level and start-vector routing
// - flags latch requests; cleared by reset, vector read, transfer accept
// - writing a vector to the clear register drops that flag only
// - levels one to six enable; zero or seven disable a source
// - watchdog request always stands at level seven
// - equal levels resolve to the lowest vector value
// - bits three and seven of a level register show live flags
// - only the best request and its vector go to the cpu
// - eight start-vector slots route a source to a transfer channel
// - single-sided, fixed and counter modes take five states of 50 ns
// - count reaching zero clears the slot's start vector
// - among transfer requests the lowest slot wins, whatever the levels
// - routed requests are presented at level six
`timescale 1ns/1ps
module ipc_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ipc_pkg::NUM_EXT-1:0] periphReq,
    input wire logic watchdogReq,
    output logic intReq,
    output logic [2:0] intLevel,
    output logic [7:0] intVector,
    output logic intIsDma,
    input wire logic vectorRead,
    input wire logic dmaAccept,
    output logic dmaBusy,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic ldcWrite,
    input wire logic ldcRead,
    input wire logic [2:0] ldcChan,
    input wire logic [1:0] ldcField,
    input wire logic [31:0] ldcWdata,
    output logic [31:0] ldcRdata,
    output logic memRead,
    output logic memWrite,
    output logic [23:0] memAddr,
    output logic [1:0] memSize,
    output logic [31:0] memWdata,
    input wire logic [31:0] memRdata
);
    typedef struct packed {
        logic [ipc_pkg::NUM_CH-1:0] flags;
        logic [ipc_pkg::NUM_CH-1:0][2:0] levels;
        logic nmiFlag;
        logic [ipc_pkg::NUM_SLOT-1:0][7:0] startVec;
        logic [ipc_pkg::NUM_SLOT-1:0][7:0] mode;
        logic [ipc_pkg::NUM_SLOT-1:0][31:0] srcPtr;
        logic [ipc_pkg::NUM_SLOT-1:0][31:0] dstPtr;
        logic [ipc_pkg::NUM_SLOT-1:0][15:0] remCnt;
        ipc_pkg::ipc_dma_state_t fsm;
        logic [2:0] slot;
        logic [3:0] cyc;
        logic intValid;
        logic [2:0] intLevel;
        logic [7:0] intVector;
        logic intIsDma;
        logic intIsNmi;
        logic [5:0] intIdx;
        logic [2:0] intSlot;
        logic memRead;
        logic memWrite;
        logic [23:0] memAddr;
        logic [1:0] memSize;
        logic [31:0] memWdata;
        logic [7:0] regRdata;
        logic [31:0] ldcRdata;
    } ipc_state_t;

    ipc_state_t q;
    ipc_state_t next_q;

    // one-hot channel mask for a vector value, empty for none or out of range
    function automatic logic [ipc_pkg::NUM_CH-1:0] chanBit(input logic [7:0] vec);
        chanBit = '0;
        for (int i = 0; i < ipc_pkg::NUM_CH; i++) begin
            if (vec == 8'(i) + ipc_pkg::VEC_STEP) begin
                chanBit[i] = 1'b1;
            end
        end
    endfunction : chanBit

    // vector value that belongs to a channel index
    function automatic logic [7:0] vecOf(input logic [5:0] idx);
        vecOf = {2'h0, idx} + ipc_pkg::VEC_STEP;
    endfunction : vecOf

    // all channels currently claimed by a start-vector slot
    function automatic logic [ipc_pkg::NUM_CH-1:0] routeMask(
        input logic [ipc_pkg::NUM_SLOT-1:0][7:0] sv);
        routeMask = '0;
        for (int s = 0; s < ipc_pkg::NUM_SLOT; s++) begin
            routeMask = routeMask | chanBit(sv[s]);
        end
    endfunction : routeMask

    ipc_arb_if arbIf ();
    ipc_step_if stepIf ();

    ipc_arbiter u_arbiter (
        .arbIf(arbIf)
    );

    ipc_step u_step (
        .stepIf(stepIf)
    );

    logic [ipc_pkg::NUM_CH-1:0] ackClear;
    logic [ipc_pkg::NUM_CH-1:0] regClear;
    logic [ipc_pkg::NUM_CH-1:0] setMask;
    logic [ipc_pkg::NUM_CH-1:0] flagsNext;
    logic [ipc_pkg::NUM_CH-1:0] routed;
    logic [ipc_pkg::NUM_CH-1:0] tcSet;
    logic [ipc_pkg::NUM_CH-1:0] tcOneHot;
    logic vecAckNormal;
    logic dmaTaken;
    logic xferDone;
    logic cntZero;
    logic nmiNext;
    logic [3:0] lastCyc;

    // the stepper always looks at the channel being served
    assign stepIf.mode = q.mode[q.slot];
    assign stepIf.src = q.srcPtr[q.slot];
    assign stepIf.dst = q.dstPtr[q.slot];
    assign stepIf.cnt = q.remCnt[q.slot];

    // last cycle of a transfer: states times cycles per state, minus one
    assign lastCyc = 4'(int'(stepIf.totalStates) * ipc_pkg::STATE_CYCLES) - 4'h1;
    assign xferDone = (q.fsm == ipc_pkg::DMA_RUN) && (q.cyc == lastCyc);
    assign cntZero = stepIf.nextCnt == 16'h0000;

    // acknowledges from the cpu against the request presented last cycle
    assign vecAckNormal = vectorRead && q.intValid && !q.intIsDma;
    assign dmaTaken = dmaAccept && q.intValid && q.intIsDma && q.fsm == ipc_pkg::DMA_IDLE;
    assign ackClear = (vecAckNormal && !q.intIsNmi) || dmaTaken ?
        chanBit(vecOf(q.intIdx)) : '0;
    assign regClear = regWrite && regAddr == ipc_pkg::CLEAR_ADDR ? chanBit(regWdata) : '0;

    // transfer-end requests sit in the top eight channels
    assign tcOneHot = ipc_pkg::NUM_CH'(1) << (ipc_pkg::TC_BASE + int'(q.slot));
    assign tcSet = xferDone && cntZero ? tcOneHot : '0;
    assign setMask = {8'h00, periphReq} | tcSet;

    // a new request in the clearing cycle survives the clear
    assign flagsNext = (q.flags & ~(ackClear | regClear)) | setMask;
    assign nmiNext = (q.nmiFlag && !(vecAckNormal && q.intIsNmi)) || watchdogReq;

    // routed channels are served as transfers, not as ordinary interrupts
    assign routed = routeMask(q.startVec);
    assign arbIf.pending = flagsNext & ~routed;
    assign arbIf.level = q.levels;

    // whole next-state computation
    always_comb begin
        logic found;
        logic [2:0] hitSlot;
        logic [5:0] hitIdx;
        found = 1'b0;
        hitSlot = 3'h0;
        hitIdx = 6'h00;
        next_q = q;
        next_q.flags = flagsNext;
        next_q.nmiFlag = nmiNext;
        next_q.memRead = 1'b0;
        next_q.memWrite = 1'b0;

        // cpu register writes: levels, start vectors, modes
        if (regWrite) begin
            for (int k = 0; k < ipc_pkg::NUM_LVL_REG; k++) begin
                if (regAddr == ipc_pkg::LEVEL_BASE + 8'(k)) begin
                    next_q.levels[2 * k] = regWdata[ipc_pkg::LVL_LO_LSB +: 3];
                    next_q.levels[2 * k + 1] = regWdata[ipc_pkg::LVL_HI_LSB +: 3];
                end
            end
            for (int s = 0; s < ipc_pkg::NUM_SLOT; s++) begin
                if (regAddr == ipc_pkg::VEC_BASE + 8'(s)) begin
                    next_q.startVec[s] = regWdata;
                end
                if (regAddr == ipc_pkg::MODE_BASE + 8'(s)) begin
                    next_q.mode[s] = regWdata;
                end
            end
        end

        // load-control writes to pointers and count
        if (ldcWrite) begin
            unique case (ldcField)
                ipc_pkg::LDC_SRC: next_q.srcPtr[ldcChan] = ldcWdata;
                ipc_pkg::LDC_DST: next_q.dstPtr[ldcChan] = ldcWdata;
                ipc_pkg::LDC_CNT: next_q.remCnt[ldcChan] = ldcWdata[15:0];
                default: next_q.remCnt[ldcChan] = q.remCnt[ldcChan];
            endcase
        end

        // register reads return flags live beside the stored levels
        next_q.regRdata = 8'h00;
        if (regRead) begin
            for (int k = 0; k < ipc_pkg::NUM_LVL_REG; k++) begin
                if (regAddr == ipc_pkg::LEVEL_BASE + 8'(k)) begin
                    next_q.regRdata[ipc_pkg::LVL_LO_LSB +: 3] = q.levels[2 * k];
                    next_q.regRdata[ipc_pkg::FLAG_LO_BIT] = q.flags[2 * k];
                    next_q.regRdata[ipc_pkg::LVL_HI_LSB +: 3] = q.levels[2 * k + 1];
                    next_q.regRdata[ipc_pkg::FLAG_HI_BIT] = q.flags[2 * k + 1];
                end
            end
            for (int s = 0; s < ipc_pkg::NUM_SLOT; s++) begin
                if (regAddr == ipc_pkg::VEC_BASE + 8'(s)) begin
                    next_q.regRdata = q.startVec[s];
                end
                if (regAddr == ipc_pkg::MODE_BASE + 8'(s)) begin
                    next_q.regRdata = q.mode[s];
                end
            end
        end

        // load-control reads
        next_q.ldcRdata = 32'h0000_0000;
        if (ldcRead) begin
            unique case (ldcField)
                ipc_pkg::LDC_SRC: next_q.ldcRdata = q.srcPtr[ldcChan];
                ipc_pkg::LDC_DST: next_q.ldcRdata = q.dstPtr[ldcChan];
                ipc_pkg::LDC_CNT: next_q.ldcRdata = {16'h0000, q.remCnt[ldcChan]};
                default: next_q.ldcRdata = 32'h0000_0000;
            endcase
        end

        // lowest pending slot wins among transfer requests
        for (int s = ipc_pkg::NUM_SLOT - 1; s >= 0; s--) begin
            for (int i = 0; i < ipc_pkg::NUM_CH; i++) begin
                if (q.startVec[s] == vecOf(6'(i)) && flagsNext[i]) begin
                    found = 1'b1;
                    hitSlot = 3'(s);
                    hitIdx = 6'(i);
                end
            end
        end

        // present one request: watchdog, then transfer, then best maskable
        next_q.intValid = 1'b0;
        next_q.intLevel = ipc_pkg::LVL_OFF;
        next_q.intVector = ipc_pkg::VEC_NONE;
        next_q.intIsDma = 1'b0;
        next_q.intIsNmi = 1'b0;
        next_q.intIdx = 6'h00;
        next_q.intSlot = 3'h0;
        if (nmiNext) begin
            next_q.intValid = 1'b1;
            next_q.intLevel = ipc_pkg::LVL_NMI;
            next_q.intVector = ipc_pkg::NMI_VECTOR;
            next_q.intIsNmi = 1'b1;
        end else if (found && q.fsm == ipc_pkg::DMA_IDLE && !dmaTaken) begin
            next_q.intValid = 1'b1;
            next_q.intLevel = ipc_pkg::LVL_DMA;
            next_q.intVector = vecOf(hitIdx);
            next_q.intIsDma = 1'b1;
            next_q.intIdx = hitIdx;
            next_q.intSlot = hitSlot;
        end else if (arbIf.winValid) begin
            next_q.intValid = 1'b1;
            next_q.intLevel = arbIf.winLevel;
            next_q.intVector = vecOf(arbIf.winIdx);
            next_q.intIdx = arbIf.winIdx;
        end

        // transfer engine: read in state three, write in state four
        unique case (q.fsm)
            ipc_pkg::DMA_IDLE: begin
                if (dmaTaken) begin
                    next_q.fsm = ipc_pkg::DMA_RUN;
                    next_q.slot = q.intSlot;
                    next_q.cyc = 4'h0;
                end
            end
            ipc_pkg::DMA_RUN: begin
                next_q.cyc = q.cyc + 4'h1;
                if (q.cyc == ipc_pkg::READ_CYC && stepIf.moves) begin
                    next_q.memRead = 1'b1;
                    next_q.memAddr = stepIf.src[23:0];
                    next_q.memSize = stepIf.size;
                end
                if (q.cyc == ipc_pkg::WRITE_CYC && stepIf.moves) begin
                    next_q.memWrite = 1'b1;
                    next_q.memAddr = stepIf.dst[23:0];
                    next_q.memSize = stepIf.size;
                    next_q.memWdata = memRdata;
                end
                if (xferDone) begin
                    next_q.fsm = ipc_pkg::DMA_IDLE;
                    next_q.cyc = 4'h0;
                    next_q.srcPtr[q.slot] = stepIf.nextSrc;
                    next_q.dstPtr[q.slot] = stepIf.nextDst;
                    next_q.remCnt[q.slot] = stepIf.nextCnt;
                    if (cntZero && !(regWrite && regAddr == ipc_pkg::VEC_BASE + 8'(q.slot))) begin
                        next_q.startVec[q.slot] = ipc_pkg::VEC_NONE;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from the state register
    assign intReq = q.intValid;
    assign intLevel = q.intLevel;
    assign intVector = q.intVector;
    assign intIsDma = q.intIsDma;
    assign dmaBusy = q.fsm == ipc_pkg::DMA_RUN;
    assign regRdata = q.regRdata;
    assign ldcRdata = q.ldcRdata;
    assign memRead = q.memRead;
    assign memWrite = q.memWrite;
    assign memAddr = q.memAddr;
    assign memSize = q.memSize;
    assign memWdata = q.memWdata;
endmodule : ipc_top

/* ipc_props.sv */
// checker of port relations of the interrupt controller top module
`timescale 1ns/1ps
module ipc_props (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic intReq,
    input wire logic [2:0] intLevel,
    input wire logic [7:0] intVector,
    input wire logic intIsDma,
    input wire logic dmaAccept,
    input wire logic dmaBusy,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdata,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [31:0] memWdata,
    input wire logic [31:0] memRdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // presented request relations
    watchdog_vector_a: assert property (intReq && intLevel == 3'h7 |-> intVector == 8'h3f)
        else $error("watchdog vector wrong");
    dma_level_a: assert property (intIsDma |-> intReq && intLevel == 3'h6)
        else $error("transfer request not at level six");
    level_enabled_a: assert property (intReq && !intIsDma |-> intLevel != 3'h0)
        else $error("disabled level presented");
    accept_busy_a: assert property (dmaAccept && intReq && intIsDma && !dmaBusy |=> dmaBusy)
        else $error("accepted transfer did not start");
    // transfer engine timing
    run_length_a: assert property ($rose(dmaBusy) |-> dmaBusy[*8] ##1 dmaBusy ##1 dmaBusy
        ##[1:3] !dmaBusy)
        else $error("transfer run length wrong");
    read_write_gap_a: assert property (memRead |-> ##2 memWrite)
        else $error("write does not follow read");
    write_data_a: assert property (memWrite |-> memWdata == $past(memRdata))
        else $error("written data differs from read data");
    mem_pulse_a: assert property (memRead |=> !memRead)
        else $error("read pulse longer than one cycle");
    // register port read data
    clear_reads_zero_a: assert property (regRead && regAddr == 8'h28 |=> regRdata == 8'h00)
        else $error("clear register read not zero");
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data without read");
endmodule : ipc_props

bind ipc_top ipc_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .intReq(intReq),
    .intLevel(intLevel), .intVector(intVector), .intIsDma(intIsDma), .dmaAccept(dmaAccept),
    .dmaBusy(dmaBusy), .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata));

/* ipc_mem_model.sv */
// memory model answering the transfer engine's read cycles
`timescale 1ns/1ps
module ipc_mem_model (
    input wire logic sys_clk,
    input wire logic memRead,
    input wire logic [23:0] memAddr,
    output logic [31:0] memRdata
);
    // data valid one cycle after a read pulse, otherwise a pattern that keeps changing
    initial memRdata = 32'h0;
    always @(posedge sys_clk) begin
        memRdata <= memRead ? {8'h5a, memAddr} : ~memRdata;
    end
endmodule : ipc_mem_model

/* tb.sv */
// self-checking bench for the interrupt controller with transfer channels
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ipc_pkg::NUM_EXT-1:0] periphReq = '0;
    logic watchdogReq = 1'b0, vectorRead = 1'b0, dmaAccept = 1'b0;
    logic regWrite = 1'b0, regRead = 1'b0, ldcWrite = 1'b0, ldcRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
    logic [2:0] ldcChan = 3'h0;
    logic [1:0] ldcField = 2'h0;
    logic [31:0] ldcWdata = 32'h0;
    logic intReq, intIsDma, dmaBusy, memRead, memWrite;
    logic [2:0] intLevel;
    logic [7:0] intVector, regRdata;
    logic [31:0] ldcRdata, memWdata, memRdata;
    logic [23:0] memAddr;
    logic [25:0] wAddr;
    logic [2:0] cpuMask = 3'h0;
    logic [1:0] memSize;
    int n_fail = 0;
    int tests_run = 0;
    int busyLen;
    logic [7:0] modes [8] = '{8'h00, 8'h05, 8'h0a, 8'h0c, 8'h11, 8'h16, 8'h18, 8'h1c};
    int dSrc [8] = '{0, 0, 4, -1, 2, -4, 0, 1};
    int dDst [8] = '{1, -2, 0, 0, 2, -4, 0, 0};
    // system clock, 25 ns period
    always #12.5 sys_clk = ~sys_clk;
    ipc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .periphReq(periphReq),
        .watchdogReq(watchdogReq), .intReq(intReq), .intLevel(intLevel), .intVector(intVector),
        .intIsDma(intIsDma), .vectorRead(vectorRead), .dmaAccept(dmaAccept), .dmaBusy(dmaBusy),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .ldcWrite(ldcWrite), .ldcRead(ldcRead), .ldcChan(ldcChan),
        .ldcField(ldcField), .ldcWdata(ldcWdata), .ldcRdata(ldcRdata), .memRead(memRead),
        .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize), .memWdata(memWdata),
        .memRdata(memRdata));
    ipc_mem_model mem (.sys_clk(sys_clk), .memRead(memRead), .memAddr(memAddr),
        .memRdata(memRdata));
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic end_of_test();
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        tick();
        regWrite = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regRead = 1'b1;
        regAddr = a;
        tick();
        regRead = 1'b0;
        chk(32'(regRdata), 32'(exp));
        tick();
    endtask : rd
    // load-control access: write, or read and compare
    task automatic load_control_register_op(input logic rdOp, input logic [1:0] f, input logic [31:0] d);
        ldcRead = rdOp;
        ldcWrite = !rdOp;
        ldcField = f;
        ldcWdata = d;
        tick();
        ldcRead = 1'b0;
        ldcWrite = 1'b0;
        if (rdOp) chk(ldcRdata, d);
        tick();
    endtask : load_control_register_op
    task automatic pulse(input logic [ipc_pkg::NUM_EXT-1:0] m, input logic w);
        periphReq = m;
        watchdogReq = w;
        tick();
        periphReq = '0;
        watchdogReq = 1'b0;
    endtask : pulse
    task automatic wait_req();
        for (int i = 0; i < 20 && intReq !== 1'b1; i++) tick();
        if (intReq !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
    endtask : wait_req
    // cpu side: take the request only above the mask, restore the mask on return
    task automatic ack();
        logic [2:0] saved;
        saved = cpuMask;
        vectorRead = intLevel > cpuMask;
        cpuMask = intLevel + 3'h1;
        tick();
        vectorRead = 1'b0;
        tick();
        cpuMask = saved;
    endtask : ack
    // main sequence: priorities first, then every transfer mode
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        tick();
        rd(8'h30, 8'h00);
        wr(8'h00, 8'h22);
        wr(8'h01, 8'h50);
        pulse(42'hf, 1'b1);
        wait_req();
        rd(8'h01, 8'hd8);
        chk(32'({intReq, intLevel, intVector}), 32'hf3f);
        ack();
        chk(32'({intReq, intLevel, intVector}), 32'hd04);
        ack();
        chk(32'({intReq, intLevel, intVector}), 32'ha01);
        wr(8'h28, 8'h02);
        rd(8'h00, 8'h2a);
        ack();
        chk(32'(intReq), 32'h0);
        for (int i = 0; i < 8; i++) begin
            load_control_register_op(1'b0, 2'h0, 32'h1000);
            load_control_register_op(1'b0, 2'h1, 32'h2000);
            load_control_register_op(1'b0, 2'h2, (i == 7) ? 32'h1 : 32'h3);
            wr(8'h30, modes[i]);
            wr(8'h20, 8'h05);
            pulse(42'h10, 1'b0);
            wait_req();
            chk(32'({intIsDma, intLevel}), 32'he);
            dmaAccept = 1'b1;
            tick();
            dmaAccept = 1'b0;
            wAddr = 26'h3ffffff;
            busyLen = 0;
            for (int k = 0; k < 40 && dmaBusy === 1'b1; k++) begin
                busyLen++;
                if (memWrite === 1'b1) wAddr = {memSize, memAddr};
                tick();
            end
            chk(32'(busyLen), (modes[i][4:2] inside {3'h4, 3'h5}) ? 32'd12 : 32'd10);
            chk(32'(wAddr), (i == 7) ? 32'h3ffffff : 32'({modes[i][1:0], 24'h2000}));
            load_control_register_op(1'b1, 2'h0, 32'(4096 + dSrc[i]));
            load_control_register_op(1'b1, 2'h1, 32'(8192 + dDst[i]));
            load_control_register_op(1'b1, 2'h2, (i == 7) ? 32'h0 : 32'h2);
        end
        rd(8'h20, 8'h00);
        rd(8'h15, 8'h08);
        end_of_test();
    end
endmodule : tb
